// ===== logic/ssel_pkg.sv
// Purpose: Shared constants and carriers for the sub map window selector.
// Assumes: Slave address bytes arrive already assembled by the two-wire front end.
// Notes: Offsets and codes are held once here and used by name in the design.
package ssel_pkg;

   // Main map register that holds the window select field.
   localparam logic [7:0] SEL_REG_OFFSET = 8'h0e;
   localparam int SEL_LSB = 5;
   localparam int SEL_MSB = 6;
   localparam logic [7:0] SEL_REG_RESET = 8'h00;

   // Window select codes.
   localparam logic [1:0] SEL_USER = 2'h0;
   localparam logic [1:0] SEL_VBI = 2'h1;
   localparam logic [1:0] SEL_USER2 = 2'h2;

   // Slave address bytes; bit 1 of the main address follows the pin.
   localparam logic [7:0] MAIN_ADDR_BASE = 8'h40;
   localparam int ADDR_PIN_BIT = 1;
   localparam logic [7:0] POST_ADDR_WRITE = 8'h84;
   localparam logic [7:0] POST_ADDR_READ = 8'h85;

   // Map that a transfer reaches.
   typedef enum logic [2:0] {
      MAP_NONE,
      MAP_USER,
      MAP_VBI,
      MAP_USER2,
      MAP_POST
   } ssel_map_e;

   // Decoded view of one slave address byte.
   typedef struct packed {
      logic hit;
      logic read;
      ssel_map_e map;
   } ssel_route_s;

   // All state of the selector.
   typedef struct packed {
      logic [7:0] ctrl;
      logic pin_meta;
      logic pin_sync;
      ssel_route_s route;
      logic [7:0] rdata;
      logic wr_ack;
   } ssel_state_s;

endpackage : ssel_pkg

// ===== logic/ssel_top.sv
// Purpose: Routes main-map register traffic to one of three sub maps or the postprocessor map.
// Assumes: A two-wire front end on MCLK_IN hands over address bytes and register accesses.
// Notes: The address pin is asynchronous and is synchronised before decoding.
//
// Behaviour
// - Three sub maps share the main-map slave address.
// - After reset the select field is 00, reaching the user sub map.
// - Field bits 6:5 of register 0x0E: 01 VBI map, 10 second user map.
// - Postprocessor map answers at 0x84 write and 0x85 read always.
// - Address pin sets bit 1 of main address: 0x40/0x41 or 0x42/0x43.
// - Address bit 0 high means read, low means write.
`timescale 1ns/1ps
module ssel_top
   import ssel_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic RSTN_IN,
   input wire logic CE_IN,
   input wire logic ADDRESS_SELECT_PIN_IN,
   input wire logic ADDR_VALID_IN,
   input wire logic [7:0] ADDR_BYTE_IN,
   input wire logic REG_WR_IN,
   input wire logic [7:0] REG_OFFSET_IN,
   input wire logic [7:0] REG_WDATA_IN,
   output logic ADDR_HIT_OUT,
   output logic READ_OUT,
   output ssel_map_e MAP_OUT,
   output logic [1:0] SUBMAP_SELECT_OUT,
   output logic [7:0] REG_RDATA_OUT,
   output logic REG_WR_ACK_OUT
);

   ssel_state_s st;
   ssel_state_s next_st;

   // Turns a select code into the sub map it opens; reserved codes fall back to user.
   function automatic ssel_map_e sub_map(input logic [1:0] code);
      unique case (code)
         SEL_VBI: sub_map = MAP_VBI;
         SEL_USER2: sub_map = MAP_USER2;
         default: sub_map = MAP_USER;
      endcase
   endfunction : sub_map

   // Decodes one slave address byte against the pin level and the current field.
   function automatic ssel_route_s decode(input logic [7:0] addr, input logic pin,
                                          input logic [1:0] code);
      ssel_route_s r;
      logic [7:0] main_addr;
      main_addr = MAIN_ADDR_BASE;
      main_addr[ADDR_PIN_BIT] = pin;
      r.read = addr[0];
      r.hit = 1'b0;
      r.map = MAP_NONE;
      if (addr == POST_ADDR_WRITE || addr == POST_ADDR_READ) begin
         r.hit = 1'b1;
         r.map = MAP_POST;
      end else if (addr[7:1] == main_addr[7:1]) begin
         r.hit = 1'b1;
         r.map = sub_map(code);
      end
      return r;
   endfunction : decode

   // Next-state logic; the select register is reachable whichever sub map is open,
   // so the host can always return to the user sub map.
   always_comb begin
      next_st = st;
      next_st.pin_meta = ADDRESS_SELECT_PIN_IN;
      next_st.pin_sync = st.pin_meta;
      next_st.wr_ack = 1'b0;
      if (ADDR_VALID_IN) begin
         next_st.route = decode(ADDR_BYTE_IN, st.pin_sync, st.ctrl[SEL_MSB:SEL_LSB]);
      end
      if (REG_WR_IN && REG_OFFSET_IN == SEL_REG_OFFSET) begin
         next_st.ctrl = REG_WDATA_IN;
         next_st.wr_ack = 1'b1;
      end
      next_st.rdata = (REG_OFFSET_IN == SEL_REG_OFFSET) ? next_st.ctrl : 8'h00;
   end

   // State register; clock enable freezes everything.
   always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         st.ctrl <= SEL_REG_RESET;
         st.pin_meta <= 1'b0;
         st.pin_sync <= 1'b0;
         st.route <= '{hit: 1'b0, read: 1'b0, map: MAP_NONE};
         st.rdata <= 8'h00;
         st.wr_ack <= 1'b0;
      end else if (CE_IN) begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state flip-flops, so no decode glitch reaches a pin.
   assign ADDR_HIT_OUT = st.route.hit;
   assign READ_OUT = st.route.read;
   assign MAP_OUT = st.route.map;
   assign SUBMAP_SELECT_OUT = st.ctrl[SEL_MSB:SEL_LSB];
   assign REG_RDATA_OUT = st.rdata;
   assign REG_WR_ACK_OUT = st.wr_ack;

   // Properties.
   property p_reset_user;
      @(posedge MCLK_IN) $rose(RSTN_IN) |-> SUBMAP_SELECT_OUT == 2'h0;
   endproperty
   a_reset_user: assert property (p_reset_user) else $error("select not 00 after reset");

   property p_post_any;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && ADDR_VALID_IN && (ADDR_BYTE_IN == 8'h84 || ADDR_BYTE_IN == 8'h85)
      |=> ADDR_HIT_OUT && MAP_OUT == MAP_POST;
   endproperty
   a_post_any: assert property (p_post_any) else $error("post map missed");

   property p_vbi;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && ADDR_VALID_IN && ADDR_BYTE_IN[7:1] == {MAIN_ADDR_BASE[7:2], st.pin_sync}
      && SUBMAP_SELECT_OUT == SEL_VBI |=> MAP_OUT == MAP_VBI;
   endproperty
   a_vbi: assert property (p_vbi) else $error("code 01 not vbi map");

   property p_user2;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && ADDR_VALID_IN && ADDR_BYTE_IN[7:1] == {MAIN_ADDR_BASE[7:2], st.pin_sync}
      && SUBMAP_SELECT_OUT == SEL_USER2 |=> MAP_OUT == MAP_USER2;
   endproperty
   a_user2: assert property (p_user2) else $error("code 10 not user map 2");

   property p_reserved;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && ADDR_VALID_IN && ADDR_BYTE_IN[7:1] == {MAIN_ADDR_BASE[7:2], st.pin_sync}
      && SUBMAP_SELECT_OUT inside {2'h0, 2'h3} |=> MAP_OUT == MAP_USER;
   endproperty
   a_reserved: assert property (p_reserved) else $error("default not user map");

   property p_pin_bit;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && ADDR_VALID_IN && ADDR_BYTE_IN[7:2] == 6'h10
      && ADDR_BYTE_IN[1] != st.pin_sync |=> !ADDR_HIT_OUT;
   endproperty
   a_pin_bit: assert property (p_pin_bit) else $error("wrong pin address accepted");

   property p_dir;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && ADDR_VALID_IN |=> READ_OUT == $past(ADDR_BYTE_IN[0]);
   endproperty
   a_dir: assert property (p_dir) else $error("direction bit lost");

   property p_shared;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && ADDR_VALID_IN && ADDR_BYTE_IN[7:1] == {MAIN_ADDR_BASE[7:2], st.pin_sync}
      |=> ADDR_HIT_OUT;
   endproperty
   a_shared: assert property (p_shared) else $error("main address not answered");

   property p_write_sel;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && REG_WR_IN && REG_OFFSET_IN == SEL_REG_OFFSET
      |=> SUBMAP_SELECT_OUT == $past(REG_WDATA_IN[SEL_MSB:SEL_LSB]) && REG_WR_ACK_OUT;
   endproperty
   a_write_sel: assert property (p_write_sel) else $error("select write lost");

   // A low clock enable must hold every state bit, the synchroniser included.
   property p_freeze;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      !CE_IN |=> $stable(st);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

   // Writes to other offsets belong to other registers and must leave the field alone.
   property p_other_offset;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && REG_WR_IN && REG_OFFSET_IN != SEL_REG_OFFSET
      |=> $stable(SUBMAP_SELECT_OUT) && !REG_WR_ACK_OUT;
   endproperty
   a_other_offset: assert property (p_other_offset) else $error("foreign offset");

   // The acknowledge is one cycle long unless another select write follows at once.
   property p_ack_pulse;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && REG_WR_ACK_OUT && !(REG_WR_IN && REG_OFFSET_IN == SEL_REG_OFFSET)
      |=> !REG_WR_ACK_OUT;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack stretched");

   // A byte for neither our main address nor the postprocessor must find no map.
   property p_miss;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && ADDR_VALID_IN && ADDR_BYTE_IN[7:1] != {MAIN_ADDR_BASE[7:2], st.pin_sync}
      && ADDR_BYTE_IN[7:1] != POST_ADDR_WRITE[7:1] |=> !ADDR_HIT_OUT && MAP_OUT == MAP_NONE;
   endproperty
   a_miss: assert property (p_miss) else $error("foreign address accepted");

   // The route stands until the next byte, since the host reads it during the whole transfer.
   property p_route_hold;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && !ADDR_VALID_IN |=> $stable(st.route);
   endproperty
   a_route_hold: assert property (p_route_hold) else $error("route changed idle");

   // Read data of the select register follows the offset one cycle later.
   property p_rdata;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && !REG_WR_IN && REG_OFFSET_IN == SEL_REG_OFFSET |=> REG_RDATA_OUT == st.ctrl;
   endproperty
   a_rdata: assert property (p_rdata) else $error("select read data wrong");

   // Other offsets read as zero, so a stale select value never leaks out.
   property p_rdata_other;
      @(posedge MCLK_IN) disable iff (!RSTN_IN)
      CE_IN && REG_OFFSET_IN != SEL_REG_OFFSET |=> REG_RDATA_OUT == 8'h00;
   endproperty
   a_rdata_other: assert property (p_rdata_other) else $error("foreign read data");

   c_vbi: cover property (@(posedge MCLK_IN) MAP_OUT == MAP_VBI);
   c_user2: cover property (@(posedge MCLK_IN) MAP_OUT == MAP_USER2);
   c_post: cover property (@(posedge MCLK_IN) MAP_OUT == MAP_POST);
   c_back: cover property (@(posedge MCLK_IN) SUBMAP_SELECT_OUT == 2'h2 ##1
                           SUBMAP_SELECT_OUT == 2'h0);

endmodule : ssel_top

// ===== verification/ssel_host_model.sv
// Purpose: Host master model issuing slave address bytes and register writes.
// Assumes: Requests launch at the falling edge and are taken at the next rising edge.
// Notes: Released data is inverted so a stale value never passes for a new one.
`timescale 1ns/1ps
module ssel_host_model
   import ssel_pkg::*;
(
   input wire logic clk_in,
   output logic valid_out,
   output logic [7:0] byte_out,
   output logic wr_out,
   output logic [7:0] offset_out,
   output logic [7:0] wdata_out
);
   // Idle bus at time zero.
   initial begin
      valid_out = 1'b0;
      byte_out = 8'h00;
      wr_out = 1'b0;
      offset_out = 8'h00;
      wdata_out = 8'h00;
   end
   // One address byte; bit 0 gives the direction.
   task automatic send_addr(input logic [7:0] b);
      @(negedge clk_in);
      valid_out = 1'b1;
      byte_out = b;
      @(negedge clk_in);
      valid_out = 1'b0;
      byte_out = ~b;
   endtask : send_addr
   // One register write; the offset stays as read select.
   task automatic write_reg(input logic [7:0] o, input logic [7:0] d);
      @(negedge clk_in);
      wr_out = 1'b1;
      offset_out = o;
      wdata_out = d;
      @(negedge clk_in);
      wr_out = 1'b0;
      wdata_out = ~d;
   endtask : write_reg
   // Leave the other sub maps by restoring the default window.
   task automatic back_to_user();
      write_reg(SEL_REG_OFFSET, 8'h00);
   endtask : back_to_user
endmodule : ssel_host_model

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the sub map window selector.
// Assumes: All inputs change at the falling clock edge.
// Notes: Expectations come from package constants, literals and loop indices, never from outputs.
`timescale 1ns/1ps
module tb_top
   import ssel_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic pin = 1'b0;
   logic ce = 1'b1;
   logic av, wr, hit, rd, ack;
   logic [7:0] ab, off, wd, rdata;
   logic [1:0] sel;
   ssel_map_e map;
   int n_mismatch = 0;
   int compares = 0;
   // Clock at 10 MHz.
   always #50 clk = ~clk;
   ssel_host_model host (.clk_in(clk), .valid_out(av), .byte_out(ab), .wr_out(wr),
      .offset_out(off), .wdata_out(wd));
   ssel_top uut (.MCLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce),
      .ADDRESS_SELECT_PIN_IN(pin), .ADDR_VALID_IN(av), .ADDR_BYTE_IN(ab),
      .REG_WR_IN(wr), .REG_OFFSET_IN(off), .REG_WDATA_IN(wd), .ADDR_HIT_OUT(hit),
      .READ_OUT(rd), .MAP_OUT(map), .SUBMAP_SELECT_OUT(sel), .REG_RDATA_OUT(rdata),
      .REG_WR_ACK_OUT(ack));
   // Compare and count.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // Every code at both pin levels, read and write bytes.
   task automatic t_maps();
      ssel_map_e e;
      for (int p = 0; p < 2; p++) begin
         @(negedge clk);
         pin = p[0];
         repeat (3) @(negedge clk);
         for (int c = 0; c < 4; c++) begin
            host.write_reg(SEL_REG_OFFSET, {1'b0, c[1:0], 5'h00});
            chk({7'h0, ack}, 8'h01);
            chk({6'h0, sel}, {6'h0, c[1:0]});
            chk(rdata, {1'b0, c[1:0], 5'h00});
            e = (c == 1) ? MAP_VBI : (c == 2) ? MAP_USER2 : MAP_USER;
            for (int r = 0; r < 2; r++) begin
               host.send_addr(MAIN_ADDR_BASE | 8'(p << 1) | 8'(r));
               chk({6'h0, hit, rd}, {6'h0, 1'b1, r[0]});
               chk(8'(map), 8'(e));
            end
         end
         host.back_to_user();
      end
   endtask : t_maps
   // Postprocessor bytes, two misses and an ignored offset.
   task automatic t_post();
      host.write_reg(SEL_REG_OFFSET, 8'h20);
      host.send_addr(POST_ADDR_WRITE);
      chk({4'h0, hit, rd, 2'h0}, 8'h08);
      chk(8'(map), 8'(MAP_POST));
      host.send_addr(POST_ADDR_READ);
      chk({7'h0, rd}, 8'h01);
      chk(8'(map), 8'(MAP_POST));
      host.send_addr(8'h44);
      chk({7'h0, hit}, 8'h00);
      host.send_addr(MAIN_ADDR_BASE);
      chk({7'h0, hit}, 8'h00);
      chk(8'(map), 8'(MAP_NONE));
      host.write_reg(8'h0d, 8'h00);
      chk({6'h0, ack, ack}, 8'h00);
      chk({6'h0, sel}, 8'h01);
      host.back_to_user();
   endtask : t_post
   // Clock enable low: a select write must leave no trace.
   task automatic t_freeze();
      ce = 1'b0;
      host.write_reg(SEL_REG_OFFSET, 8'h40);
      chk({6'h0, sel}, 8'h00);
      chk({7'h0, ack}, 8'h00);
      ce = 1'b1;
   endtask : t_freeze
   // Watchdog.
   initial begin
      #1000000;
      n_mismatch++;
      end_of_test();
   end
   // Main sequence.
   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk({6'h0, sel}, 8'h00);
      chk(8'(map), 8'(MAP_NONE));
      t_freeze();
      t_maps();
      t_post();
      end_of_test();
   end
endmodule : tb_top
